// File: dv/port_pin_override_logic_tb_top.sv
// Self-checking bench for the port pin override block
`timescale 1ns/10ps

module port_pin_override_logic_tb_top;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, load = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, r, r2;
    logic [31:0] seed = 32'h0000ab36;
    logic [3:0]  avs_byteenable = 4'h3;
    logic [2:0]  sleep_mode = 3'h0;
    logic [7:0]  pad_in = 8'h00, pad_out, pad_oe, pad_pullup, alt_digital_input;
    logic [7:0]  alt_analog_pad, ext_int_req, alt_sync, m_dir, m_out, m_ie;
    logic        m_pud, avs_waitrequest;
    logic [63:0] ovr_word = 64'h0, ovr_q;
    logic [4:0]  offs [6] = '{5'h00, 5'h04, 5'h0c, 5'h10, 5'h14, 5'h18};
    int          n_fail = 0, n_compared = 0;

    // 20 MHz I/O clock
    always #25 sys_clk = ~sys_clk;

    ppo_port ppo_port_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode),
        .pull_up_override_enable(ovr_q[7:0]), .pull_up_override_value(ovr_q[15:8]),
        .direction_override_enable(ovr_q[23:16]), .direction_override_value(ovr_q[31:24]),
        .value_override_enable(ovr_q[39:32]), .value_override_value(ovr_q[47:40]),
        .input_enable_override_enable(ovr_q[55:48]),
        .input_enable_override_value(ovr_q[63:56]), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pullup(pad_pullup), .alt_digital_input(alt_digital_input),
        .alt_analog_pad(alt_analog_pad), .ext_int_req(ext_int_req));

    ppo_alt_fn ppo_alt_fn_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(load),
        .ovr_word(ovr_word), .alt_in(alt_digital_input), .ovr_q(ovr_q), .alt_sync(alt_sync));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic results();
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // One Avalon cycle; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int k;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= wd;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            n_fail++;
            results();
        end
    endtask

    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd[7:0]);
        chk("read_upper", 8'h00, rd[31:24] | rd[23:16] | rd[15:8]);
    endtask

    // Reference pin model, compared once inputs have settled
    task automatic pins_chk();
        logic [7:0] eoe, epu, eie, epv;
        eoe = (ovr_word[23:16] & ovr_word[31:24]) | (~ovr_word[23:16] & m_dir);
        epu = (ovr_word[7:0] & ovr_word[15:8]) | (~ovr_word[7:0] & ~m_dir & m_out & {8{~m_pud}});
        epv = (ovr_word[39:32] & ovr_word[47:40]) | (~ovr_word[39:32] & m_out);
        eie = (ovr_word[55:48] & ovr_word[63:56])
            | (~ovr_word[55:48] & ((sleep_mode inside {3'h3, 3'h4, 3'h5, 3'h6}) ? m_ie : 8'hff));
        @(negedge sys_clk);
        chk("pad_oe", eoe, pad_oe);
        chk("pad_out", epv & eoe, pad_out & eoe);
        chk("pad_pullup", epu, pad_pullup);
        chk("alt_digital_input", pad_in & eie, alt_digital_input);
        chk("alt_analog_pad", pad_in, alt_analog_pad);
        rd_chk("input_sync", ppo_pkg::OFF_INPUT_SYNC, pad_in & eie);
        chk("alt_sync", pad_in & eie, alt_sync);
    endtask

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        results();
    end

    // Main sequence
    initial
    begin
        m_dir = 8'h00; m_out = 8'h00; m_pud = 1'b0; m_ie = 8'h00;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("reset_pad_oe", 8'h00, pad_oe);
        chk("reset_pullup", 8'h00, pad_pullup);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (offs[i]) rd_chk("reset_value", offs[i], 8'h00);
        rd_chk("unmapped", 5'h1c, 8'h00);
        bus(1'b1, ppo_pkg::OFF_INPUT_SYNC, 32'h0000_00ff);
        pins_chk();
        // Random configurations, all sleep modes and override mixes
        repeat (24)
        begin
            r = rnd(); r2 = rnd();
            m_dir = r[7:0]; m_out = r[15:8]; m_pud = r[16]; m_ie = r[31:24];
            bus(1'b1, ppo_pkg::OFF_DIRECTION, {r2[31:8], m_dir});
            bus(1'b1, ppo_pkg::OFF_OUT_VALUE, {r2[23:0], m_out});
            bus(1'b1, ppo_pkg::OFF_PULL_CTRL, {r2[30:0], m_pud});
            bus(1'b1, ppo_pkg::OFF_INT_ENABLE, {24'h0, m_ie});
            ovr_word   <= {rnd(), rnd()} & {rnd(), rnd()};
            load       <= 1'b1;
            pad_in     <= r2[15:8];
            sleep_mode <= (r2[2:0] == 3'h7) ? 3'h0 : r2[2:0];
            @(posedge sys_clk);
            load <= 1'b0;
            repeat (3) @(posedge sys_clk);
            pins_chk();
            rd_chk("direction", ppo_pkg::OFF_DIRECTION, m_dir);
        end
        // Wake from power-down with edge-sensed, unenabled high pins
        @(posedge sys_clk);
        ovr_word <= 64'h0; load <= 1'b1; sleep_mode <= 3'h0; pad_in <= 8'hf0;
        @(posedge sys_clk);
        load <= 1'b0;
        m_ie = 8'h30;
        bus(1'b1, ppo_pkg::OFF_INT_ENABLE, {24'h0, m_ie});
        bus(1'b1, ppo_pkg::OFF_INT_SENSE, 32'h0000_e4e4);
        bus(1'b1, ppo_pkg::OFF_INT_FLAG, 32'h0000_00ff);
        rd_chk("int_flag_clear", ppo_pkg::OFF_INT_FLAG, 8'h00);
        @(posedge sys_clk);
        sleep_mode <= 3'h3;
        repeat (4) @(posedge sys_clk);
        sleep_mode <= 3'h0;
        repeat (6) @(posedge sys_clk);
        rd_chk("int_flag_wake", ppo_pkg::OFF_INT_FLAG, 8'hc0);
        @(negedge sys_clk);
        chk("ext_int_req", 8'h00, ext_int_req);
        m_ie = 8'hc0;
        bus(1'b1, ppo_pkg::OFF_INT_ENABLE, {24'h0, m_ie});
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("ext_int_req", 8'hc0, ext_int_req);
        bus(1'b1, ppo_pkg::OFF_INT_FLAG, 32'h0000_0040);
        rd_chk("int_flag_w1c", ppo_pkg::OFF_INT_FLAG, 8'h80);
        // Pull-ups and drivers on, then a reset in mid-run
        m_dir = 8'h0f; m_out = 8'hff; m_pud = 1'b0;
        bus(1'b1, ppo_pkg::OFF_DIRECTION, {24'h0, m_dir});
        bus(1'b1, ppo_pkg::OFF_OUT_VALUE, {24'h0, m_out});
        bus(1'b1, ppo_pkg::OFF_PULL_CTRL, 32'h0);
        repeat (2) @(posedge sys_clk);
        pins_chk();
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("midrun_pullup", 8'h00, pad_pullup);
        chk("midrun_pad_oe", 8'h00, pad_oe);
        results();
    end
endmodule // port_pin_override_logic_tb_top

// File: dv/ppo_alt_fn.sv
// Behavioural alternate-function peripheral feeding the port overrides
`timescale 1ns/10ps

module ppo_alt_fn (
    input  wire logic        sys_clk,   // I/O clock
    input  wire logic        sys_rst,   // Sync reset, high
    input  wire logic        load,      // Take a new override set
    input  wire logic [63:0] ovr_word,  // Packed override enables and values
    input  wire logic [7:0]  alt_in,    // Unsynchronised pin input
    output logic      [63:0] ovr_q,     // Override enables and values
    output logic      [7:0]  alt_sync   // Own synchronised copy
);
    logic [7:0] meta;

    // Override set made inside the peripheral, held as a level
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ovr_q <= 64'h0;
        else if (load)
            ovr_q <= ovr_word;
    end

    // Two stages, since the port hands the input over raw
    always_ff @(posedge sys_clk)
    begin
        meta     <= alt_in;
        alt_sync <= meta;
    end
endmodule // ppo_alt_fn

// File: verilog/ppo_in_sync.sv
// Package of shared constants and the pin input synchroniser
`timescale 1ns/10ps

package ppo_pkg;
    localparam int          PIN_COUNT        = 8;
    localparam int          ADDR_W           = 5;
    localparam int          SENSE_W          = 2 * PIN_COUNT;
    // Register byte offsets
    localparam logic [4:0]  OFF_OUT_VALUE    = 5'h00;
    localparam logic [4:0]  OFF_DIRECTION    = 5'h04;
    localparam logic [4:0]  OFF_INPUT_SYNC   = 5'h08;
    localparam logic [4:0]  OFF_PULL_CTRL    = 5'h0c;
    localparam logic [4:0]  OFF_INT_ENABLE   = 5'h10;
    localparam logic [4:0]  OFF_INT_SENSE    = 5'h14;
    localparam logic [4:0]  OFF_INT_FLAG     = 5'h18;
    // Field positions and reset values
    localparam int          PUD_BIT          = 0;
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [15:0] RST_SENSE        = 16'h0000;
    localparam logic [31:0] RD_ZERO          = 32'h0000_0000;
    // Cycles from wake until the synchronised pin is trusted
    localparam int          WAKE_SETTLE      = 2;
    // Sleep controller modes
    typedef enum logic [2:0] {
        PPO_SLP_ACTIVE      = 3'b000,
        PPO_SLP_IDLE        = 3'b001,
        PPO_SLP_ADC_NR      = 3'b010,
        PPO_SLP_PWR_DOWN    = 3'b011,
        PPO_SLP_PWR_SAVE    = 3'b100,
        PPO_SLP_STANDBY     = 3'b101,
        PPO_SLP_EXT_STANDBY = 3'b110
    } ppo_sleep_t;
    // External interrupt sense per pin
    typedef enum logic [1:0] {
        PPO_SENSE_LEVEL     = 2'b00,
        PPO_SENSE_ANY       = 2'b01,
        PPO_SENSE_FALL      = 2'b10,
        PPO_SENSE_RISE      = 2'b11
    } ppo_sense_t;
endpackage

module ppo_in_sync (
    input  wire logic                          sys_clk,   // I/O clock
    input  wire logic                          sys_rst,   // Sync reset, high
    input  wire logic [ppo_pkg::PIN_COUNT-1:0] gated_in,  // Clamped pad levels
    output logic      [ppo_pkg::PIN_COUNT-1:0] sync_out   // Synchronised levels
);
    logic [ppo_pkg::PIN_COUNT-1:0] half_stage;

    // First stage catches on the falling edge, standing in for the latch
    always_ff @(negedge sys_clk)
    begin
        if (sys_rst)
            half_stage <= '0;
        else
            half_stage <= gated_in;
    end

    // Second stage gives the half to one and a half period delay
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            sync_out <= '0;
        else
            sync_out <= half_stage;
    end
endmodule // ppo_in_sync

// File: verilog/ppo_port.sv
// One eight-pin I/O port with alternate-function overrides and sleep clamp
// Contract
// - Clamp digital input to ground in power-down, power-save and standby modes.
// - Pins with enabled external interrupt escape the clamp; disabled ones do not.
// - Input enable override controls can also lift the sleep clamp.
// - Unenabled edge-sensed interrupt pin high at wake sets its flag.
// - Pull-up is off while reset is active.
// - Without pull-up override, pull-up on only when direction, value, disable are 010.
// - With pull-up override, pull-up follows its override value only.
// - Driver enable follows direction bit unless direction override is enabled.
// - With direction override, driver follows override value only.
// - Driven value comes from value override if enabled, else output bit.
// - With value override enabled, port value equals override value.
// - Input enable follows sleep state unless its override is enabled.
// - With input enable override, input enable follows override value only.
// - Alternate digital input taken after clamp, before synchroniser, unsynchronised.
// - Analog tap connects straight to the pad, bypassing digital buffering.
// - Strobes shared per port; clock, sleep, pull-up disable shared; rest per pin.
// - Direction bit one makes an output, zero an input.
// - As output, value bit drives level; as input, value one enables pull-up.
// - Pins go high impedance when reset becomes active.
// - Pin passes half-period stage then input sync bit, half to 1.5 period delay.
`timescale 1ns/10ps

module ppo_port (
    input  wire logic        sys_clk,                       // I/O clock, 20 MHz
    input  wire logic        sys_rst,                       // Sync reset, high
    input  wire logic [4:0]  avs_address,                   // Byte address
    input  wire logic        avs_read,                      // Read request
    input  wire logic        avs_write,                     // Write request
    input  wire logic [31:0] avs_writedata,                 // Write data
    input  wire logic [3:0]  avs_byteenable,                // Byte lanes
    output logic      [31:0] avs_readdata,                  // Read data
    output logic             avs_waitrequest,               // Stall
    input  wire logic [2:0]  sleep_mode,                    // Sleep controller state
    input  wire logic [7:0]  pull_up_override_enable,       // Per pin
    input  wire logic [7:0]  pull_up_override_value,        // Per pin
    input  wire logic [7:0]  direction_override_enable,     // Per pin
    input  wire logic [7:0]  direction_override_value,      // Per pin
    input  wire logic [7:0]  value_override_enable,         // Per pin
    input  wire logic [7:0]  value_override_value,          // Per pin
    input  wire logic [7:0]  input_enable_override_enable,  // Per pin
    input  wire logic [7:0]  input_enable_override_value,   // Per pin
    input  wire logic [7:0]  pad_in,                        // Pad level, async
    output logic      [7:0]  pad_out,                       // Pad drive value
    output logic      [7:0]  pad_oe,                        // Pad driver enable
    output logic      [7:0]  pad_pullup,                    // Pull-up enable
    output logic      [7:0]  alt_digital_input,             // Unsynchronised input
    output logic      [7:0]  alt_analog_pad,                // Raw pad tap
    output logic      [7:0]  ext_int_req                    // Flag and enable
);
    logic [7:0]  output_value_bit;
    logic [7:0]  direction_bit;
    logic [7:0]  input_sync_bit;
    logic        global_pullup_disable;
    logic [7:0]  int_enable;
    logic [15:0] int_sense;
    logic [7:0]  int_flag;
    logic [7:0]  sync_prev;
    logic [7:0]  digital_in_en;
    logic [7:0]  gated_in;
    logic [7:0]  next_pad_out;
    logic [7:0]  next_pad_oe;
    logic [7:0]  next_pad_pullup;
    logic [7:0]  flag_set;
    logic        clamp_mode;
    logic        clamp_prev;
    logic [ppo_pkg::WAKE_SETTLE-1:0] wake_dly;
    logic        wr_take;
    logic        wr_b0;
    logic        wr_b1;

    // Clamping sleep modes; shared by every pin of every port
    always_comb
    begin
        case (ppo_pkg::ppo_sleep_t'(sleep_mode))
            ppo_pkg::PPO_SLP_PWR_DOWN,
            ppo_pkg::PPO_SLP_PWR_SAVE,
            ppo_pkg::PPO_SLP_STANDBY,
            ppo_pkg::PPO_SLP_EXT_STANDBY: clamp_mode = 1'b1;
            default:                      clamp_mode = 1'b0;
        endcase
    end

    // Per-pin control; overrides arrive ready-made from each peripheral
    genvar g;
    generate
        for (g = 0; g < ppo_pkg::PIN_COUNT; g++)
        begin : g_pin
            logic [1:0] sense;
            logic       pin_set;
            assign sense = int_sense[2*g +: 2];
            assign flag_set[g] = pin_set;
            // Input enable: override first, else sleep clamp unless interrupt armed
            assign digital_in_en[g] = input_enable_override_enable[g]
                ? input_enable_override_value[g]
                : ~(clamp_mode & ~int_enable[g]);
            assign gated_in[g] = pad_in[g] & digital_in_en[g];
            assign next_pad_oe[g] = direction_override_enable[g]
                ? direction_override_value[g]
                : direction_bit[g];
            assign next_pad_out[g] = value_override_enable[g]
                ? value_override_value[g]
                : output_value_bit[g];
            assign next_pad_pullup[g] = pull_up_override_enable[g]
                ? pull_up_override_value[g]
                : (~direction_bit[g] & output_value_bit[g]
                   & ~global_pullup_disable);
            // Edge detection on the synchronised level, plus the wake case
            // Local bit per pin, so no two processes share one vector
            always_comb
            begin
                pin_set = 1'b0;
                case (ppo_pkg::ppo_sense_t'(sense))
                    ppo_pkg::PPO_SENSE_ANY:
                        pin_set = input_sync_bit[g] ^ sync_prev[g];
                    ppo_pkg::PPO_SENSE_FALL:
                        pin_set = ~input_sync_bit[g] & sync_prev[g];
                    ppo_pkg::PPO_SENSE_RISE:
                        pin_set = input_sync_bit[g] & ~sync_prev[g];
                    default:
                        pin_set = 1'b0;
                endcase
                // Clamp release looks like an edge; report it for idle pins too
                if (wake_dly[ppo_pkg::WAKE_SETTLE-1] && !int_enable[g]
                    && sense != ppo_pkg::PPO_SENSE_LEVEL && input_sync_bit[g])
                    pin_set = 1'b1;
            end
        end
    endgenerate

    // Alternate inputs bypass the synchroniser; consumers must sync their own
    assign alt_digital_input = gated_in;
    assign alt_analog_pad    = pad_in;

    // Pin synchroniser, half-period stage then input sync bit
    ppo_in_sync u_sync (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .gated_in (gated_in),
        .sync_out (input_sync_bit)
    );

    // Pad drivers; reset releases the pad and drops the pull-up
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pad_oe     <= ppo_pkg::RST_BYTE;
            pad_out    <= ppo_pkg::RST_BYTE;
            pad_pullup <= ppo_pkg::RST_BYTE;
        end
        else
        begin
            pad_oe     <= next_pad_oe;
            pad_out    <= next_pad_out;
            pad_pullup <= next_pad_pullup;
        end
    end

    // Wake tracking, delayed until the synchroniser has settled
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            clamp_prev <= 1'b0;
            wake_dly   <= '0;
            sync_prev  <= ppo_pkg::RST_BYTE;
        end
        else
        begin
            clamp_prev <= clamp_mode;
            wake_dly   <= {wake_dly[ppo_pkg::WAKE_SETTLE-2:0], clamp_prev & ~clamp_mode};
            sync_prev  <= input_sync_bit;
        end
    end

    // Bus handshake: one wait cycle, then the transfer completes
    assign wr_take = avs_write & ~avs_waitrequest;
    assign wr_b0   = wr_take & avs_byteenable[0];
    assign wr_b1   = wr_take & avs_byteenable[1];

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else if ((avs_read || avs_write) && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    // Port write strobes; one decode serves all pins of the port
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            output_value_bit      <= ppo_pkg::RST_BYTE;
            direction_bit         <= ppo_pkg::RST_BYTE;
            global_pullup_disable <= 1'b0;
            int_enable            <= ppo_pkg::RST_BYTE;
        end
        else if (wr_b0)
        begin
            if (avs_address == ppo_pkg::OFF_OUT_VALUE)
                output_value_bit <= avs_writedata[7:0];
            else if (avs_address == ppo_pkg::OFF_DIRECTION)
                direction_bit <= avs_writedata[7:0];
            else if (avs_address == ppo_pkg::OFF_PULL_CTRL)
                global_pullup_disable <= avs_writedata[ppo_pkg::PUD_BIT];
            else if (avs_address == ppo_pkg::OFF_INT_ENABLE)
                int_enable <= avs_writedata[7:0];
        end
    end

    // Sense field spans two byte lanes
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            int_sense <= ppo_pkg::RST_SENSE;
        else if (avs_address == ppo_pkg::OFF_INT_SENSE)
        begin
            if (wr_b0)
                int_sense[7:0] <= avs_writedata[7:0];
            if (wr_b1)
                int_sense[15:8] <= avs_writedata[15:8];
        end
    end

    // Flags clear by writing one; a new event in the same cycle wins
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            int_flag <= ppo_pkg::RST_BYTE;
        else if (wr_b0 && avs_address == ppo_pkg::OFF_INT_FLAG)
            int_flag <= (int_flag & ~avs_writedata[7:0]) | flag_set;
        else
            int_flag <= int_flag | flag_set;
    end

    // Request toward the interrupt controller
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ext_int_req <= ppo_pkg::RST_BYTE;
        else
            ext_int_req <= int_flag & int_enable;
    end

    // Read data captured on the request edge; unmapped reads return zero
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            avs_readdata <= ppo_pkg::RD_ZERO;
        else if (avs_read && avs_waitrequest)
        begin
            if (avs_address == ppo_pkg::OFF_OUT_VALUE)
                avs_readdata <= {24'h00_0000, output_value_bit};
            else if (avs_address == ppo_pkg::OFF_DIRECTION)
                avs_readdata <= {24'h00_0000, direction_bit};
            else if (avs_address == ppo_pkg::OFF_INPUT_SYNC)
                avs_readdata <= {24'h00_0000, input_sync_bit};
            else if (avs_address == ppo_pkg::OFF_PULL_CTRL)
                avs_readdata <= {31'h0000_0000, global_pullup_disable};
            else if (avs_address == ppo_pkg::OFF_INT_ENABLE)
                avs_readdata <= {24'h00_0000, int_enable};
            else if (avs_address == ppo_pkg::OFF_INT_SENSE)
                avs_readdata <= {16'h0000, int_sense};
            else if (avs_address == ppo_pkg::OFF_INT_FLAG)
                avs_readdata <= {24'h00_0000, int_flag};
            else
                avs_readdata <= ppo_pkg::RD_ZERO;
        end
    end

    // Checks on the pin control paths
    property p_pullup_default;
        @(posedge sys_clk) disable iff (sys_rst)
        (pull_up_override_enable[0] == 1'b0 && direction_bit[0] == 1'b0
         && output_value_bit[0] && !global_pullup_disable)
        |=> pad_pullup[0];
    endproperty
    a_pullup_default: assert property (p_pullup_default)
        else $error("pull-up not enabled in 010 state");

    property p_pullup_override;
        @(posedge sys_clk) disable iff (sys_rst)
        pull_up_override_enable[1] |=> pad_pullup[1] == $past(pull_up_override_value[1]);
    endproperty
    a_pullup_override: assert property (p_pullup_override)
        else $error("pull-up ignores override value");

    property p_reset_release;
        @(posedge sys_clk)
        sys_rst |=> (pad_oe == 8'h00 && pad_pullup == 8'h00);
    endproperty
    a_reset_release: assert property (p_reset_release)
        else $error("pad driven or pulled up after reset");

    property p_dir_plain;
        @(posedge sys_clk) disable iff (sys_rst)
        !direction_override_enable[2] |=> pad_oe[2] == $past(direction_bit[2]);
    endproperty
    a_dir_plain: assert property (p_dir_plain)
        else $error("driver enable not following direction bit");

    property p_dir_override;
        @(posedge sys_clk) disable iff (sys_rst)
        direction_override_enable[3] |=> pad_oe[3] == $past(direction_override_value[3]);
    endproperty
    a_dir_override: assert property (p_dir_override)
        else $error("driver enable ignores override");

    property p_value_sel;
        @(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> pad_out[4] == ($past(value_override_enable[4])
            ? $past(value_override_value[4]) : $past(output_value_bit[4]));
    endproperty
    a_value_sel: assert property (p_value_sel)
        else $error("pad value source wrong");

    property p_clamp;
        @(posedge sys_clk) disable iff (sys_rst)
        (clamp_mode && !int_enable[5] && !input_enable_override_enable[5])
        |-> alt_digital_input[5] == 1'b0;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("input not clamped in deep sleep");

    property p_die_override;
        @(posedge sys_clk) disable iff (sys_rst)
        (input_enable_override_enable[6] && input_enable_override_value[6])
        |-> alt_digital_input[6] == pad_in[6];
    endproperty
    a_die_override: assert property (p_die_override)
        else $error("input enable override not honoured");

    property p_dir_write;
        @(posedge sys_clk) disable iff (sys_rst)
        (wr_b0 && avs_address == ppo_pkg::OFF_DIRECTION)
        |=> direction_bit == $past(avs_writedata[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write lost");

    sequence s_wake_high;
        clamp_mode ##1 (!clamp_mode && !int_enable[7]
            && int_sense[15:14] != ppo_pkg::PPO_SENSE_LEVEL
            && pad_in[7] && !input_enable_override_enable[7]) [*4];
    endsequence
    property p_wake_flag;
        @(posedge sys_clk) disable iff (sys_rst)
        s_wake_high |-> int_flag[7];
    endproperty
    a_wake_flag: assert property (p_wake_flag)
        else $error("wake did not set idle interrupt flag");
endmodule // ppo_port
